// ### fws_flash_model.sv
`timescale 1ns/1ps
`default_nettype none

module fws_flash_model (
	input wire logic ce_n,
	input wire logic oe_n,
	input wire logic we_n,
	input wire logic [7:0] dOut,
	input wire logic dOe,
	input wire logic arm,
	input wire logic [7:0] busyCount,
	input wire logic stuck,
	input wire logic erase,
	input wire logic [7:0] value,
	input wire logic suspend,
	output logic [7:0] dIn,
	output logic rbLow,
	output logic sawReset
);
	logic busy;
	logic [7:0] left;
	logic tog;
	logic sec;
	logic tf;
	logic hold;
	logic [7:0] lastDrv;
	logic [7:0] cur;
	initial
	begin
		busy = 1'b0;
		tog = 1'b0;
		sec = 1'b0;
		tf = 1'b0;
		sawReset = 1'b0;
		lastDrv = 8'h00;
	end
	// status valid from the final command strobe.
	always @(posedge arm)
	begin
		busy = 1'b1;
		left = busyCount;
		tf = 1'b0;
		sawReset = 1'b0;
	end
	// A suspended erase freezes the busy window and the toggle bit.
	assign hold = erase && suspend;
	// status byte, the same at every address.
	assign cur = busy ? {erase ? suspend : ~value[7], tog, tf, value[4:3], erase ? sec : value[2], value[1:0]} : value;
	always @(posedge oe_n)
	begin
		lastDrv = cur;
		if (busy)
		begin
			sec = ~sec;
			if (!hold)
			begin
				tog = ~tog;
				if (left > 8'h01)
					left = left - 8'h01;
				else if (!stuck)
					busy = 1'b0;
				else
					tf = 1'b1;
			end
		end
	end
	always @(posedge we_n)
		if (dOe && dOut == 8'hF0)
		begin
			busy = 1'b0;
			tf = 1'b0;
			sawReset = 1'b1;
		end
	// Released pins show the inverse of the last byte so stale data cannot pass.
	assign dIn = (!ce_n && !oe_n) ? cur : ~lastDrv;
	// busy pulls low, released in erase suspend.
	assign rbLow = busy && !hold;
endmodule

`default_nettype wire

// ### fws_host.sv
// Functional notes
// - Host reads program address when polling.
// - Host reads erasing sector when polling erase.
// - Final data taken from a later read.
// - Host reads twice and compares toggle bits.
// - Toggling with timeout flag: recheck, then fail.
// - Resumed polling restarts from first read.
// - Timeout seen: reread the polling bit.
// - After failure host writes reset command.
//
// The Avalon-MM interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "fws_params.svh"

module fws_host #(
	parameter int ADDR_W = 22,
	parameter logic [7:0] RESET_CMD = 8'hF0
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [ADDR_W-1:0] flashAddr,
	output logic flashCe_n,
	output logic flashOe_n,
	output logic flashWe_n,
	input wire logic [7:0] flashDataIn,
	output logic [7:0] flashDataOut,
	output logic flashDataOe,
	input wire logic readyBusy_n
);
	logic waitReq_reg;
	logic [31:0] readData_reg;
	logic [31:0] pollAddr_reg;
	logic [7:0] expect_reg;
	logic toggleMode_reg;
	logic done_reg;
	logic fail_reg;
	logic [7:0] dataS1_reg, dataS2_reg, dataS3_reg;
	logic rbS1_reg, rbS2_reg, rbS3_reg, rbStable_reg;
	fws_pkg::fws_state_t state_reg;
	fws_pkg::fws_phase_t phase_reg;
	logic [3:0] cnt_reg;
	logic [7:0] lastData_reg;
	logic prevToggle_reg;
	logic [7:0] readCount_reg;
	logic timeoutSeen_reg;
	logic resetSent_reg;
	logic [ADDR_W-1:0] addrOut_reg;
	logic ceN_reg, oeN_reg, weN_reg, dataOe_reg;
	logic [7:0] dataOut_reg;
	logic busTake, startReq, abortReq, pollMatch, sameToggle, gapDone;
	logic [31:0] statusWord;

	assign busTake = avs_write && !waitReq_reg;
	assign startReq = busTake && avs_address == `FWS_OFS_CTRL && avs_writedata[`FWS_CTRL_START]
		&& state_reg == fws_pkg::FWS_IDLE;
	assign abortReq = busTake && avs_address == `FWS_OFS_CTRL && avs_writedata[`FWS_CTRL_ABORT];
	assign pollMatch = lastData_reg[`FWS_BIT_POLL] == expect_reg[`FWS_BIT_POLL];
	assign sameToggle = lastData_reg[`FWS_BIT_TOGGLE] == prevToggle_reg;
	assign gapDone = cnt_reg >= 4'(`FWS_GAP_CYC - 1);
	assign statusWord = {16'h0000, lastData_reg, 4'h0, rbStable_reg, fail_reg, done_reg,
		state_reg != fws_pkg::FWS_IDLE};

	// Slave answers every request one cycle after it is raised.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			waitReq_reg <= 1'b1;
			readData_reg <= 32'h0000_0000;
		end
		else if ((avs_read || avs_write) && waitReq_reg)
		begin
			waitReq_reg <= 1'b0;
			unique case (avs_address)
				`FWS_OFS_CTRL: readData_reg <= {30'h0, toggleMode_reg, 1'b0};
				`FWS_OFS_ADDR: readData_reg <= pollAddr_reg;
				`FWS_OFS_EXPECT: readData_reg <= {24'h00_0000, expect_reg};
				`FWS_OFS_STATUS: readData_reg <= statusWord;
				default: readData_reg <= 32'h0000_0000;
			endcase
		end
		else
		begin
			waitReq_reg <= 1'b1;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			pollAddr_reg <= `FWS_RST_ADDR;
			expect_reg <= `FWS_RST_EXPECT;
			toggleMode_reg <= 1'b0;
		end
		else if (busTake && state_reg == fws_pkg::FWS_IDLE)
		begin
			if (avs_address == `FWS_OFS_ADDR)
				pollAddr_reg <= avs_writedata;
			if (avs_address == `FWS_OFS_EXPECT)
				expect_reg <= avs_writedata[7:0];
			if (avs_address == `FWS_OFS_CTRL)
				toggleMode_reg <= avs_writedata[`FWS_CTRL_TOGGLE];
		end
	end

	// Pin inputs pass three stages; a value counts once stages two and three agree.
	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			dataS1_reg <= 8'h00;
			dataS2_reg <= 8'h00;
			dataS3_reg <= 8'h00;
			rbS1_reg <= 1'b1;
			rbS2_reg <= 1'b1;
			rbS3_reg <= 1'b1;
			rbStable_reg <= 1'b1;
		end
		else
		begin
			dataS1_reg <= flashDataIn;
			dataS2_reg <= dataS1_reg;
			dataS3_reg <= dataS2_reg;
			rbS1_reg <= readyBusy_n;
			rbS2_reg <= rbS1_reg;
			rbS3_reg <= rbS2_reg;
			if (rbS2_reg == rbS3_reg)
				rbStable_reg <= rbS3_reg;
		end
	end

	always_ff @(posedge ref_clk)
	begin
		if (rst)
		begin
			state_reg <= fws_pkg::FWS_IDLE;
			phase_reg <= fws_pkg::FWS_PH_FIRST;
			cnt_reg <= 4'h0;
			lastData_reg <= 8'h00;
			prevToggle_reg <= 1'b0;
			readCount_reg <= 8'h00;
			timeoutSeen_reg <= 1'b0;
			resetSent_reg <= 1'b0;
			done_reg <= 1'b0;
			fail_reg <= 1'b0;
			addrOut_reg <= '0;
			ceN_reg <= 1'b1;
			oeN_reg <= 1'b1;
			weN_reg <= 1'b1;
			dataOe_reg <= 1'b0;
			dataOut_reg <= 8'h00;
		end
		else
		begin
			cnt_reg <= cnt_reg + 4'h1;
			unique case (state_reg)
				fws_pkg::FWS_IDLE:
				begin
					if (startReq)
					begin
						state_reg <= fws_pkg::FWS_RDLOW;
						phase_reg <= fws_pkg::FWS_PH_FIRST;
						readCount_reg <= 8'h00;
						timeoutSeen_reg <= 1'b0;
						resetSent_reg <= 1'b0;
						done_reg <= 1'b0;
						fail_reg <= 1'b0;
						cnt_reg <= 4'h0;
						addrOut_reg <= pollAddr_reg[ADDR_W-1:0];
						ceN_reg <= 1'b0;
						oeN_reg <= 1'b0;
					end
				end
				fws_pkg::FWS_RDLOW:
				begin
					if (cnt_reg >= 4'(`FWS_ACC_CYC - 1))
					begin
						state_reg <= fws_pkg::FWS_RDSYNC;
						cnt_reg <= 4'h0;
					end
				end
				fws_pkg::FWS_RDSYNC:
				begin
					if (cnt_reg >= 4'(`FWS_SYNC_CYC - 1) && dataS2_reg == dataS3_reg)
					begin
						lastData_reg <= dataS3_reg;
						if (readCount_reg != 8'hFF)
							readCount_reg <= readCount_reg + 8'h01;
						ceN_reg <= 1'b1;
						oeN_reg <= 1'b1;
						state_reg <= fws_pkg::FWS_RDHIGH;
						cnt_reg <= 4'h0;
					end
				end
				fws_pkg::FWS_RDHIGH:
				begin
					if (abortReq)
						state_reg <= fws_pkg::FWS_IDLE;
					else if (gapDone)
					begin
						cnt_reg <= 4'h0;
						state_reg <= fws_pkg::FWS_RDLOW;
						ceN_reg <= 1'b0;
						oeN_reg <= 1'b0;
						if (lastData_reg[`FWS_BIT_TIMEOUT])
							timeoutSeen_reg <= 1'b1;
						if (!toggleMode_reg)
						begin
							unique case (phase_reg)
								fws_pkg::FWS_PH_FIRST:
								begin
									if (pollMatch)
										phase_reg <= fws_pkg::FWS_PH_NEXT;
									else if (lastData_reg[`FWS_BIT_TIMEOUT])
										phase_reg <= fws_pkg::FWS_PH_RECHECK;
								end
								fws_pkg::FWS_PH_NEXT:
								begin
									done_reg <= 1'b1;
									state_reg <= fws_pkg::FWS_IDLE;
									ceN_reg <= 1'b1;
									oeN_reg <= 1'b1;
								end
								default:
								begin
									if (pollMatch)
										phase_reg <= fws_pkg::FWS_PH_NEXT;
									else
									begin
										state_reg <= fws_pkg::FWS_WRLOW;
										oeN_reg <= 1'b1;
										weN_reg <= 1'b0;
										dataOe_reg <= 1'b1;
										dataOut_reg <= RESET_CMD;
									end
								end
							endcase
						end
						else
						begin
							prevToggle_reg <= lastData_reg[`FWS_BIT_TOGGLE];
							unique case (phase_reg)
								fws_pkg::FWS_PH_FIRST:
									phase_reg <= fws_pkg::FWS_PH_NEXT;
								fws_pkg::FWS_PH_NEXT:
								begin
									if (sameToggle)
									begin
										done_reg <= 1'b1;
										state_reg <= fws_pkg::FWS_IDLE;
										ceN_reg <= 1'b1;
										oeN_reg <= 1'b1;
									end
									else if (lastData_reg[`FWS_BIT_TIMEOUT])
										phase_reg <= fws_pkg::FWS_PH_RECHECK;
								end
								default:
								begin
									if (sameToggle)
									begin
										done_reg <= 1'b1;
										state_reg <= fws_pkg::FWS_IDLE;
										ceN_reg <= 1'b1;
										oeN_reg <= 1'b1;
									end
									else
									begin
										state_reg <= fws_pkg::FWS_WRLOW;
										oeN_reg <= 1'b1;
										weN_reg <= 1'b0;
										dataOe_reg <= 1'b1;
										dataOut_reg <= RESET_CMD;
									end
								end
							endcase
						end
					end
				end
				fws_pkg::FWS_WRLOW:
				begin
					if (cnt_reg >= 4'(`FWS_WE_CYC - 1))
					begin
						weN_reg <= 1'b1;
						state_reg <= fws_pkg::FWS_WRHIGH;
						cnt_reg <= 4'h0;
					end
				end
				fws_pkg::FWS_WRHIGH:
				begin
					if (gapDone)
					begin
						ceN_reg <= 1'b1;
						dataOe_reg <= 1'b0;
						resetSent_reg <= 1'b1;
						fail_reg <= 1'b1;
						done_reg <= 1'b1;
						state_reg <= fws_pkg::FWS_IDLE;
					end
				end
			endcase
		end
	end

	assign avs_readdata = readData_reg;
	assign avs_waitrequest = waitReq_reg;
	assign flashAddr = addrOut_reg;
	assign flashCe_n = ceN_reg;
	assign flashOe_n = oeN_reg;
	assign flashWe_n = weN_reg;
	assign flashDataOut = dataOut_reg;
	assign flashDataOe = dataOe_reg;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (rst);

	poll_address_a: assert property (!oeN_reg |-> addrOut_reg == pollAddr_reg[ADDR_W-1:0])
		else $error("Status read at wrong address.");
	addr_stable_a: assert property (!oeN_reg && $past(!oeN_reg) |-> $stable(addrOut_reg))
		else $error("Address moved during read.");
	final_read_a: assert property ($rose(done_reg) && !fail_reg && !toggleMode_reg |-> readCount_reg >= 8'h02)
		else $error("Poll finished without later read.");
	double_read_a: assert property ($rose(done_reg) && !fail_reg && toggleMode_reg |-> readCount_reg >= 8'h02)
		else $error("Toggle check used fewer than two reads.");
	fail_cause_a: assert property ($rose(fail_reg) |-> timeoutSeen_reg && readCount_reg >= 8'h02)
		else $error("Failure without timeout flag.");
	restart_first_a: assert property (startReq |=> phase_reg == fws_pkg::FWS_PH_FIRST && readCount_reg == 8'h00
		&& !oeN_reg)
		else $error("Start did not restart at first read.");
	poll_recheck_a: assert property (!toggleMode_reg && $rose(fail_reg) |-> !pollMatch)
		else $error("Poll failed despite matching bit.");
	reset_cmd_a: assert property ($fell(weN_reg) |-> dataOe_reg && dataOut_reg == RESET_CMD ##1
		(!weN_reg && dataOe_reg) [*3])
		else $error("Reset command strobe malformed.");
	fail_after_reset_a: assert property ($rose(fail_reg) |-> resetSent_reg)
		else $error("Failure reported before reset command.");
	no_clash_a: assert property (!(dataOe_reg && !oeN_reg) && !(!weN_reg && !oeN_reg))
		else $error("Bus drive clash.");
endmodule
`default_nettype wire

// ### fws_host_bench.sv
`timescale 1ns/1ps
`default_nettype none
`include "fws_params.svh"

module fws_host_bench;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [21:0] flashAddr;
	logic ce_n, oe_n, we_n, dOe, rbLow, sawReset;
	logic [7:0] dOut, dIn;
	logic arm = 1'b0, stuck = 1'b0, erase = 1'b0, suspend = 1'b0;
	logic [7:0] busyCount = 8'h01, value = 8'h00;
	wire logic readyBusy_n = rbLow ? 1'b0 : 1'b1;
	int failures = 0, checked = 0;
	logic [31:0] seed = 32'h501B997E;
	always #5 ref_clk = ~ref_clk;
	fws_host dut_u (.ref_clk(ref_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .flashAddr(flashAddr), .flashCe_n(ce_n), .flashOe_n(oe_n),
		.flashWe_n(we_n), .flashDataIn(dIn), .flashDataOut(dOut), .flashDataOe(dOe), .readyBusy_n(readyBusy_n));
	fws_flash_model model_u (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .dOut(dOut), .dOe(dOe), .arm(arm),
		.busyCount(busyCount), .stuck(stuck), .erase(erase), .value(value), .dIn(dIn), .rbLow(rbLow),
		.suspend(suspend), .sawReset(sawReset));
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	function automatic logic [3:0] expFlags(input logic f);
		return {1'b1, f, 1'b1, 1'b0};
	endfunction
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp)
		begin
			failures++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic print_verdict();
		if (failures == 0 && checked > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task automatic av(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
		int n;
		n = 0;
		avs_address <= a;
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= d;
		@(posedge ref_clk);
		while (avs_waitrequest !== 1'b0 && n < 100)
		begin
			@(posedge ref_clk);
			n++;
		end
		if (n >= 100)
			failures++;
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic runOp(input logic tgl, input logic er, input logic stk, input logic sus);
		logic [31:0] a, q, ctl;
		logic [7:0] v;
		int n;
		a = rnd();
		v = er ? 8'hFF : 8'(rnd());
		ctl = 32'h0;
		ctl[`FWS_CTRL_START] = 1'b1;
		ctl[`FWS_CTRL_TOGGLE] = tgl;
		value <= v;
		erase <= er;
		stuck <= stk;
		suspend <= sus;
		busyCount <= 8'h01 + 8'(rnd() % 5);
		@(posedge ref_clk);
		arm <= 1'b1;
		@(posedge ref_clk);
		arm <= 1'b0;
		repeat (`FWS_SYNC_CYC + 2) @(posedge ref_clk);
		av(1'b1, `FWS_OFS_ADDR, a, q);
		av(1'b1, `FWS_OFS_EXPECT, {24'h0, v}, q);
		av(1'b1, `FWS_OFS_CTRL, ctl, q);
		av(1'b0, `FWS_OFS_STATUS, 32'h0, q);
		chk("busy ready", {30'h0, q[`FWS_ST_READY], q[`FWS_ST_BUSY]}, {30'h0, sus, 1'b1});
		n = 0;
		while (q[`FWS_ST_DONE] !== 1'b1 && n < 300)
		begin
			av(1'b0, `FWS_OFS_STATUS, 32'h0, q);
			n++;
		end
		if (n >= 300)
			failures++;
		// Ready/busy reaches the status word only through the pin synchroniser.
		repeat (`FWS_SYNC_CYC + 2) @(posedge ref_clk);
		av(1'b0, `FWS_OFS_STATUS, 32'h0, q);
		chk("flags", {28'h0, q[3:0]}, {28'h0, expFlags(stk)});
		if (sus)
			chk("suspend poll", {31'h0, q[15]}, 32'h1);
		else if (!stk)
			chk("data", {24'h0, q[15:8]}, {24'h0, v});
		chk("reset cmd", {31'h0, sawReset}, {31'h0, stk});
		chk("address", {10'h0, flashAddr}, {10'h0, a[21:0]});
		av(1'b0, `FWS_OFS_ADDR, 32'h0, q);
		chk("addr reg", q, a);
		av(1'b0, `FWS_OFS_CTRL, 32'h0, q);
		chk("mode", {31'h0, q[`FWS_CTRL_TOGGLE]}, {31'h0, tgl});
	endtask
	initial
	begin
		#400000;
		failures++;
		print_verdict();
	end
	initial
	begin
		logic [31:0] q;
		int n;
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		av(1'b0, 4'h2, 32'h0, q);
		chk("unmapped", q, 32'h0);
		runOp(1'b0, 1'b0, 1'b1, 1'b0);
		runOp(1'b1, 1'b0, 1'b1, 1'b0);
		for (int i = 0; i < 9; i++)
			runOp(i % 3 == 1, i % 3 == 2, 1'b0, 1'b0);
		runOp(1'b1, 1'b1, 1'b0, 1'b1);
		stuck <= 1'b1;
		erase <= 1'b0;
		suspend <= 1'b0;
		busyCount <= 8'hFF;
		@(posedge ref_clk);
		arm <= 1'b1;
		@(posedge ref_clk);
		arm <= 1'b0;
		av(1'b1, `FWS_OFS_CTRL, 32'h1 << `FWS_CTRL_START, q);
		// Abort is honoured only in the read gap, so the request is repeated at shifting phases.
		n = 0;
		q = 32'h1;
		while (q[`FWS_ST_BUSY] !== 1'b0 && n < 50)
		begin
			av(1'b1, `FWS_OFS_CTRL, 32'h1 << `FWS_CTRL_ABORT, q);
			av(1'b0, `FWS_OFS_STATUS, 32'h0, q);
			repeat (n % 5) @(posedge ref_clk);
			n++;
		end
		chk("abort", {29'h0, q[2:0]}, 32'h0);
		print_verdict();
	end
endmodule

`default_nettype wire

// ### fws_params.svh
`ifndef FWS_PARAMS_SVH
`define FWS_PARAMS_SVH

`define FWS_CLK_MHZ 100
`define FWS_OFS_CTRL 4'h0
`define FWS_OFS_ADDR 4'h4
`define FWS_OFS_EXPECT 4'h8
`define FWS_OFS_STATUS 4'hC
`define FWS_CTRL_START 0
`define FWS_CTRL_TOGGLE 1
`define FWS_CTRL_ABORT 2
`define FWS_ST_BUSY 0
`define FWS_ST_DONE 1
`define FWS_ST_FAIL 2
`define FWS_ST_READY 3
`define FWS_ST_DATA_LSB 8
`define FWS_BIT_POLL 7
`define FWS_BIT_TOGGLE 6
`define FWS_BIT_TIMEOUT 5
`define FWS_RST_ADDR 32'h0000_0000
`define FWS_RST_EXPECT 8'h00
`define FWS_ACC_NS 70
`define FWS_WE_NS 35
`define FWS_GAP_NS 20
`define FWS_ACC_CYC ((`FWS_ACC_NS * `FWS_CLK_MHZ + 999) / 1000)
`define FWS_WE_CYC ((`FWS_WE_NS * `FWS_CLK_MHZ + 999) / 1000)
`define FWS_GAP_CYC ((`FWS_GAP_NS * `FWS_CLK_MHZ + 999) / 1000)
`define FWS_SYNC_CYC 3

`endif

// ### fws_pkg.sv
package fws_pkg;
	typedef enum logic [2:0]
	{
		FWS_IDLE = 3'h0,
		FWS_RDLOW = 3'h1,
		FWS_RDSYNC = 3'h3,
		FWS_RDHIGH = 3'h2,
		FWS_WRLOW = 3'h6,
		FWS_WRHIGH = 3'h7
	} fws_state_t;
	typedef enum logic [1:0]
	{
		FWS_PH_FIRST = 2'h0,
		FWS_PH_NEXT = 2'h1,
		FWS_PH_RECHECK = 2'h2
	} fws_phase_t;
endpackage
